// ### core/opc_cfg.svh
`ifndef OPC_CFG_SVH
`define OPC_CFG_SVH

// Register byte offsets; configuration words sit at index = offset / 4
`define OFS_CTRL        8'h00
`define OFS_CFG_LAST    8'h34
`define OFS_STATUS      8'h38
`define OFS_IRQ_STAT    8'h3c
`define OFS_IRQ_MASK    8'h40

// Configuration word indexes
`define CFG_WORDS       14
`define IDX_CTRL        4'd0
`define IDX_PWM_LO      4'd1
`define IDX_PWM_HI      4'd2
`define IDX_PWM_ALARM   4'd3
`define IDX_PERIOD      4'd4
`define IDX_MIN_ON      4'd5
`define IDX_MIN_OFF     4'd6
`define IDX_RLY_LEVEL   4'd7
`define IDX_RLY_HYST    4'd8
`define IDX_CUR_IN_LO   4'd9
`define IDX_CUR_IN_HI   4'd10
`define IDX_CUR_OUT_LO  4'd11
`define IDX_CUR_OUT_HI  4'd12
`define IDX_CUR_ALARM   4'd13

// Control word fields
`define CTRL_PWM_EN     0
`define CTRL_RLY_EN     1
`define CTRL_CUR_EN     2
`define CTRL_MASK       16'h0007

// Reset values
`define RST_CTRL        16'h0000
`define RST_PWM_HI      16'h03e8
`define RST_PERIOD      16'h03e8
`define RST_MIN_HOLD    16'h0064
`define RST_CUR_IN_HI   16'h03e8
`define RST_CUR_OUT_LO  16'h0fa0
`define RST_CUR_OUT_HI  16'h4e20
`define RST_CUR_ALARM   16'h0fa0

// Timing: 50 MHz clock, millisecond time base
`define CLK_PERIOD_NS   20
`define MS_NS           1000000
`define MS_CYCLES       (`MS_NS / `CLK_PERIOD_NS)
// Shortest period, 0.1 s, held in milliseconds
`define PERIOD_MIN_MS   16'd100

// Hardware current limits in microamperes (3 to 22 mA)
`define CUR_HW_MIN_UA   16'd3000
`define CUR_HW_MAX_UA   16'd22000

// Interrupt event bits
`define EVT_WIDTH       4

`endif

// ### core/opc_pkg.sv
package opc_pkg;

	// Quality reported by the source channel with each value
	typedef enum logic [1:0] {
		SRC_OK,
		SRC_ERROR,
		SRC_BELOW_RANGE_STATE,
		SRC_ABOVE_RANGE_STATE
	} src_state_t;

	typedef struct packed {
		logic signed [15:0] value;
		src_state_t         state;
	} src_sample_t;

	// Everything the block drives toward the output stages
	typedef struct packed {
		logic        pwmOut;
		logic        relayOut;
		logic [15:0] currentUa;
	} drive_t;

	typedef enum logic [1:0] {
		DIV_LOAD,
		DIV_RUN,
		DIV_DONE
	} div_state_t;

endpackage

// ### core/seq_divider.sv
`timescale 1ns/1ps
// Free-running restoring divider: loads, runs 32 steps, reports, reloads.
module seq_divider (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             done,
	output logic [15:0]      quotient
);
	import opc_pkg::*;

	div_state_t  state_r;
	logic [31:0] quo_r;
	logic [16:0] rem_r;
	logic [15:0] den_r;
	logic [4:0]  step_r;
	logic [16:0] shifted;

	assign shifted = {rem_r[15:0], quo_r[31]};

	// One bit per cycle; slow but tiny, and the users change slowly
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= DIV_LOAD;
			quo_r   <= 32'h0000_0000;
			rem_r   <= 17'h0_0000;
			den_r   <= 16'h0000;
			step_r  <= 5'h00;
		end else begin
			case (state_r)
			DIV_LOAD: begin
				quo_r   <= dividend;
				rem_r   <= 17'h0_0000;
				den_r   <= divisor;
				step_r  <= 5'h00;
				state_r <= DIV_RUN;
			end
			DIV_RUN: begin
				if (shifted >= {1'b0, den_r}) begin
					rem_r <= shifted - {1'b0, den_r};
					quo_r <= {quo_r[30:0], 1'b1};
				end else begin
					rem_r <= shifted;
					quo_r <= {quo_r[30:0], 1'b0};
				end
				step_r <= step_r + 5'h01;
				if (step_r == 5'h1f) begin
					state_r <= DIV_DONE;
				end
			end
			default: begin
				state_r <= DIV_LOAD;
			end
			endcase
		end
	end

	// Result saturates; a zero divisor yields all ones and callers guard it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done     <= 1'b0;
			quotient <= 16'h0000;
		end else begin
			done <= (state_r == DIV_DONE);
			if (state_r == DIV_DONE) begin
				quotient <= (|quo_r[31:16]) ? 16'hffff : quo_r[15:0];
			end
		end
	end

endmodule

// ### core/hyst_relay.sv
`timescale 1ns/1ps
// Next state of a below-level relay with symmetric hysteresis
module hyst_relay (
	input  wire logic signed [15:0] value,
	input  wire logic signed [15:0] level,
	input  wire logic        [15:0] hyst,
	input  wire logic               isOn,
	output logic                    nextOn
);
	logic signed [17:0] valueExt;
	logic signed [17:0] onThr;
	logic signed [17:0] offThr;

	// Widened so level +/- hysteresis never wraps
	assign valueExt = {{2{value[15]}}, value};
	assign onThr    = {{2{level[15]}}, level} - $signed({2'b00, hyst});
	assign offThr   = {{2{level[15]}}, level} + $signed({2'b00, hyst});

	always_comb begin
		if (hyst == 16'h0000) begin
			nextOn = (valueExt < onThr);
		end else if (valueExt < onThr) begin
			nextOn = 1'b1;
		end else if (valueExt > offThr) begin
			nextOn = 1'b0;
		end else begin
			nextOn = isOn;
		end
	end

endmodule

// ### core/threshold_pwm_and_current_output.sv
`timescale 1ns/1ps
`include "opc_cfg.svh"

// What this block does
// - PWM duty is zero, no high time, while value is below lower level.
// - PWM is high all period above upper level; duty varies in between.
// - Duty equals high time divided by the output period.
// - In alarm the PWM uses the alarm value against the same levels.
// - Alarm means source error, below-range or above-range state.
// - Period is one full output cycle, never shorter than 0.1 s.
// - Once high, PWM stays high at least the minimum high time.
// - Once low, PWM stays low at least the minimum low time.
// - Current path clamps the source to input lower and upper levels.
// - Clamped input maps linearly onto output levels, limited to that range.
// - In alarm the current is the alarm value limited to 3-22 mA.
// - Relay turns on below level minus hysteresis, off above level plus it.
// - Relay-type outputs show low as zero and high as one.
// - Below-level relay is high while value is under level, else low.
module threshold_pwm_and_current_output #(
	parameter int TICK_CYCLES = `MS_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           regAddr,
	input  wire logic [31:0]          regWrData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic      [31:0]          regRdData,
	input  wire opc_pkg::src_sample_t src,
	output opc_pkg::drive_t           drive,
	output logic                      irq
);
	import opc_pkg::*;

	logic        [15:0]           cfg_r [0:`CFG_WORDS-1];
	logic        [`EVT_WIDTH-1:0] irqStat_r;
	logic        [`EVT_WIDTH-1:0] irqMask_r;
	logic        [`EVT_WIDTH-1:0] events;
	logic        [31:0]           rdMux;
	logic        [15:0]           tickCnt_r;
	logic                         msTick;
	logic        [15:0]           periodCnt_r;
	logic        [15:0]           highTime_r;
	logic        [15:0]           highTimeNxt;
	logic        [15:0]           stateMs_r;
	logic        [15:0]           minHold;
	logic                         boundary;
	logic                         pwm_r;
	logic                         pwmNxt;
	logic                         relay_r;
	logic                         relayNxt;
	logic                         relayCalc;
	logic        [15:0]           current_r;
	logic                         alarm;
	logic                         alarmPrev_r;
	logic signed [15:0]           effVal;
	logic        [15:0]           pwmNum;
	logic        [15:0]           pwmDen;
	logic                         pwmDivDone;
	logic        [15:0]           pwmQuot;
	logic signed [15:0]           curX;
	logic        [15:0]           curNum;
	logic        [15:0]           curDen;
	logic        [15:0]           curSpan;
	logic                         curRising;
	logic                         curDivDone;
	logic        [15:0]           curQuot;
	logic        [15:0]           curLin;
	logic        [15:0]           curOutMin;
	logic        [15:0]           curOutMax;

	// Named views of the configuration words
	logic signed [15:0] pwmLo;
	logic signed [15:0] pwmHi;
	logic signed [15:0] inLo;
	logic signed [15:0] inHi;
	logic        [15:0] period;
	logic        [15:0] outLo;
	logic        [15:0] outHi;
	logic               pwmEn;
	logic               relayEn;
	logic               curEn;

	assign pwmLo   = cfg_r[`IDX_PWM_LO];
	assign pwmHi   = cfg_r[`IDX_PWM_HI];
	assign inLo    = cfg_r[`IDX_CUR_IN_LO];
	assign inHi    = cfg_r[`IDX_CUR_IN_HI];
	assign period  = cfg_r[`IDX_PERIOD];
	assign outLo   = cfg_r[`IDX_CUR_OUT_LO];
	assign outHi   = cfg_r[`IDX_CUR_OUT_HI];
	assign pwmEn   = cfg_r[`IDX_CTRL][`CTRL_PWM_EN];
	assign relayEn = cfg_r[`IDX_CTRL][`CTRL_RLY_EN];
	assign curEn   = cfg_r[`IDX_CTRL][`CTRL_CUR_EN];

	function automatic logic [15:0] cfgReset(input logic [3:0] idx);
		case (idx)
		`IDX_CTRL:       cfgReset = `RST_CTRL;
		`IDX_PWM_HI:     cfgReset = `RST_PWM_HI;
		`IDX_PERIOD:     cfgReset = `RST_PERIOD;
		`IDX_MIN_ON:     cfgReset = `RST_MIN_HOLD;
		`IDX_MIN_OFF:    cfgReset = `RST_MIN_HOLD;
		`IDX_CUR_IN_HI:  cfgReset = `RST_CUR_IN_HI;
		`IDX_CUR_OUT_LO: cfgReset = `RST_CUR_OUT_LO;
		`IDX_CUR_OUT_HI: cfgReset = `RST_CUR_OUT_HI;
		`IDX_CUR_ALARM:  cfgReset = `RST_CUR_ALARM;
		default:         cfgReset = 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] clampU(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		clampU = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register port

	// Configuration writes; the period is floored so it never drops below 0.1 s
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `CFG_WORDS; i++) begin
				cfg_r[i] <= cfgReset(4'(i));
			end
		end else if (regWrite && regAddr <= `OFS_CFG_LAST && regAddr[1:0] == 2'b00) begin
			if (regAddr[5:2] == `IDX_PERIOD && regWrData[15:0] < `PERIOD_MIN_MS) begin
				cfg_r[`IDX_PERIOD] <= `PERIOD_MIN_MS;
			end else if (regAddr[5:2] == `IDX_CTRL) begin
				cfg_r[`IDX_CTRL] <= regWrData[15:0] & `CTRL_MASK;
			end else begin
				cfg_r[regAddr[5:2]] <= regWrData[15:0];
			end
		end
	end

	// Read mux; unmapped or misaligned addresses read zero
	always_comb begin
		rdMux = 32'h0000_0000;
		if (regAddr <= `OFS_CFG_LAST && regAddr[1:0] == 2'b00) begin
			rdMux = {16'h0000, cfg_r[regAddr[5:2]]};
		end else if (regAddr == `OFS_STATUS) begin
			rdMux = {current_r, 13'h0000, alarm, relay_r, pwm_r};
		end else if (regAddr == `OFS_IRQ_STAT) begin
			rdMux = {28'h000_0000, irqStat_r};
		end else if (regAddr == `OFS_IRQ_MASK) begin
			rdMux = {28'h000_0000, irqMask_r};
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= 32'h0000_0000;
		end else begin
			regRdData <= regRead ? rdMux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts

	// Alarm entry, alarm exit, period boundary, relay change
	assign events = {relayNxt != relay_r, boundary, alarmPrev_r && !alarm,
		alarm && !alarmPrev_r};

	// Set beats a write-one-to-clear in the same cycle so no event is lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStat_r   <= '0;
			irqMask_r   <= '0;
			alarmPrev_r <= 1'b0;
		end else begin
			alarmPrev_r <= alarm;
			if (regWrite && regAddr == `OFS_IRQ_STAT) begin
				irqStat_r <= (irqStat_r & ~regWrData[`EVT_WIDTH-1:0]) | events;
			end else begin
				irqStat_r <= irqStat_r | events;
			end
			if (regWrite && regAddr == `OFS_IRQ_MASK) begin
				irqMask_r <= regWrData[`EVT_WIDTH-1:0];
			end
		end
	end

	assign irq = |(irqStat_r & irqMask_r);

	////////////////////////////////////////////////////////////////////////////
	// Source quality and millisecond time base

	assign alarm  = (src.state != SRC_OK);
	assign effVal = alarm ? $signed(cfg_r[`IDX_PWM_ALARM]) : src.value;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_r <= 16'h0000;
		end else begin
			tickCnt_r <= msTick ? 16'h0000 : tickCnt_r + 16'h0001;
		end
	end

	assign msTick = (tickCnt_r == 16'(TICK_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////
	// PWM generator

	// Position between the levels; divided by the span in the divider below
	assign pwmDen = (pwmHi > pwmLo) ? 16'(pwmHi - pwmLo) : 16'h0000;
	assign pwmNum = (effVal > pwmLo) ? 16'(effVal - pwmLo) : 16'h0000;

	seq_divider pwmDiv (
		.clk      (clk),
		.arst_n   (arst_n),
		.dividend (32'(pwmNum) * 32'(period)),
		.divisor  (pwmDen),
		.done     (pwmDivDone),
		.quotient (pwmQuot)
	);

	// High time of the coming period: duty times period
	always_comb begin
		if (effVal >= pwmHi) begin
			highTimeNxt = period;
		end else if (effVal <= pwmLo || pwmDen == 16'h0000) begin
			highTimeNxt = 16'h0000;
		end else begin
			highTimeNxt = pwmQuot;
		end
	end

	// Shrinking the period mid-cycle ends the current one at the next millisecond tick
	assign boundary = msTick && (periodCnt_r >= period - 16'h0001);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			periodCnt_r <= 16'h0000;
			highTime_r  <= 16'h0000;
		end else if (boundary) begin
			periodCnt_r <= 16'h0000;
			highTime_r  <= highTimeNxt;
		end else if (msTick) begin
			periodCnt_r <= periodCnt_r + 16'h0001;
		end
	end

	// A level may only be left once it has been held longer than its minimum
	assign minHold = pwm_r ? cfg_r[`IDX_MIN_ON] : cfg_r[`IDX_MIN_OFF];

	always_comb begin
		pwmNxt = pwm_r;
		if ((pwmEn && periodCnt_r < highTime_r) != pwm_r) begin
			if (minHold == 16'h0000 || stateMs_r > minHold) begin
				pwmNxt = !pwm_r;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_r     <= 1'b0;
			stateMs_r <= 16'h0000;
		end else begin
			pwm_r <= pwmNxt;
			if (pwmNxt != pwm_r) begin
				stateMs_r <= 16'h0000;
			end else if (msTick && stateMs_r != 16'hffff) begin
				stateMs_r <= stateMs_r + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Below-level relay

	hyst_relay belowRelay (
		.value  (src.value),
		.level  ($signed(cfg_r[`IDX_RLY_LEVEL])),
		.hyst   (cfg_r[`IDX_RLY_HYST]),
		.isOn   (relay_r),
		.nextOn (relayCalc)
	);

	// Alarm freezes the relay rather than guessing a safe side
	assign relayNxt = !relayEn ? 1'b0 : (alarm ? relay_r : relayCalc);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			relay_r <= 1'b0;
		end else begin
			relay_r <= relayNxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Current output setpoint

	assign curX = (src.value < inLo) ? inLo : ((src.value > inHi) ? inHi : src.value);
	assign curNum    = (curX > inLo) ? 16'(curX - inLo) : 16'h0000;
	assign curDen    = (inHi > inLo) ? 16'(inHi - inLo) : 16'h0000;
	assign curRising = (outHi >= outLo);
	assign curSpan   = curRising ? outHi - outLo : outLo - outHi;
	assign curOutMin = curRising ? outLo : outHi;
	assign curOutMax = curRising ? outHi : outLo;

	seq_divider curDiv (
		.clk      (clk),
		.arst_n   (arst_n),
		.dividend (32'(curNum) * 32'(curSpan)),
		.divisor  (curDen),
		.done     (curDivDone),
		.quotient (curQuot)
	);

	// Output levels may run downward; the line then falls from lower to upper
	always_comb begin
		if (curDen == 16'h0000) begin
			curLin = outLo;
		end else if (curRising) begin
			curLin = clampU(outLo + curQuot, curOutMin, curOutMax);
		end else begin
			curLin = clampU(outLo - curQuot, curOutMin, curOutMax);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			current_r <= 16'h0000;
		end else if (!curEn) begin
			current_r <= 16'h0000;
		end else if (alarm) begin
			current_r <= clampU(cfg_r[`IDX_CUR_ALARM], `CUR_HW_MIN_UA, `CUR_HW_MAX_UA);
		end else if (curDivDone) begin
			current_r <= curLin;
		end
	end

	assign drive = '{pwmOut: pwm_r, relayOut: relay_r, currentUa: current_r};

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence alarmHeld;
		alarm [*2];
	endsequence

	sequence pwmDrops;
		pwm_r ##1 !pwm_r;
	endsequence

	sequence pwmRises;
		!pwm_r ##1 pwm_r;
	endsequence

	AST_ZERO_DUTY: assert property (
		(boundary && effVal < pwmLo) |=> (highTime_r == 16'h0000))
		else $error("high time not zero below lower level");

	AST_FULL_DUTY: assert property (
		(boundary && effVal > pwmHi) |=> (highTime_r == $past(period)))
		else $error("high time not full period above upper level");

	AST_ALARM_VALUE: assert property (
		(src.state != SRC_OK) |-> (effVal == $signed(cfg_r[`IDX_PWM_ALARM])))
		else $error("alarm value not substituted for pwm");

	AST_PERIOD_FLOOR: assert property (
		period >= `PERIOD_MIN_MS)
		else $error("period below minimum");

	AST_MIN_ON: assert property (
		pwmDrops |-> ($past(minHold) == 16'h0000 || $past(stateMs_r) > $past(minHold)))
		else $error("pwm left high before minimum high time");

	AST_MIN_OFF: assert property (
		pwmRises |-> ($past(minHold) == 16'h0000 || $past(stateMs_r) > $past(minHold)))
		else $error("pwm left low before minimum low time");

	AST_CUR_ALARM: assert property (
		(alarmHeld and curEn [*2]) |-> (current_r >= `CUR_HW_MIN_UA
			&& current_r <= `CUR_HW_MAX_UA))
		else $error("alarm current outside hardware range");

	AST_CUR_RANGE: assert property (
		(curEn && !alarm && curDivDone && curDen != 16'h0000) |=>
			(current_r >= $past(curOutMin) && current_r <= $past(curOutMax)))
		else $error("current outside output range");

	AST_RELAY_OFF_WHEN_DISABLED: assert property (
		!relayEn |=> !relay_r)
		else $error("relay high while disabled");

	AST_PERIOD_RESTART: assert property (
		boundary |=> (periodCnt_r == 16'h0000) ##1 (periodCnt_r <= 16'h0001))
		else $error("period counter did not restart");

endmodule

// ### verification/pwm_load_model.sv
`timescale 1ns/1ps
// PWM load and current loop on the far side: both only listen to the block
module pwm_load_model (
	input  wire logic             clk,
	input  wire logic             clear,
	input  wire opc_pkg::drive_t  drv,
	output logic      [31:0]      highCycles,
	output logic      [31:0]      shortHigh,
	output logic      [31:0]      shortLow,
	output logic      [15:0]      loopUa
);
	import opc_pkg::*;
	logic        [31:0] runLen;
	logic               lastLvl;
	logic               seenEdge;

	////////////////////////////////////////////////////////////////
	// Loop current simply follows the setpoint; a passive loop has no say
	assign loopUa = drv.currentUa;

	// High time summed over whole periods gives the duty seen by the load
	// The run before the first edge is partial, so it never counts as shortest
	always @(posedge clk) begin
		if (clear) begin
			highCycles <= 32'h0;
			shortHigh  <= 32'hffffffff;
			shortLow   <= 32'hffffffff;
			seenEdge   <= 1'b0;
			runLen     <= 32'h0;
		end else begin
			highCycles <= highCycles + 32'(drv.pwmOut);
			if (drv.pwmOut != lastLvl) begin
				if (seenEdge && lastLvl && runLen < shortHigh) begin
					shortHigh <= runLen;
				end
				if (seenEdge && !lastLvl && runLen < shortLow) begin
					shortLow <= runLen;
				end
				seenEdge <= 1'b1;
				runLen   <= 32'h1;
			end else begin
				runLen <= runLen + 32'h1;
			end
		end
		lastLvl <= drv.pwmOut;
	end
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "opc_cfg.svh"
module testbench;
	import opc_pkg::*;
	logic               clk = 1'b0;
	logic               arst_n;
	logic        [7:0]  regAddr;
	logic        [31:0] regWrData;
	logic               regWrite;
	logic               regRead;
	logic        [31:0] regRdData;
	src_sample_t        src;
	drive_t             drive;
	logic               irq;
	logic               clear;
	logic        [31:0] highCycles;
	logic        [31:0] shortHigh;
	logic        [31:0] shortLow;
	logic        [15:0] loopUa;
	logic               rdPend = 1'b0;
	int                 n_fail;
	int                 num_checks;
	logic        [31:0] expQ[$];
	logic        [31:0] mskQ[$];
	logic        [31:0] rv;
	logic        [3:0]  rstIdx[6] = '{`IDX_CTRL, `IDX_PWM_HI, `IDX_PERIOD, `IDX_MIN_ON,
		`IDX_CUR_OUT_HI, `IDX_CUR_ALARM};
	logic        [15:0] rstVal[6] = '{`RST_CTRL, `RST_PWM_HI, `RST_PERIOD, `RST_MIN_HOLD,
		`RST_CUR_OUT_HI, `RST_CUR_ALARM};
	logic signed [15:0] rlyVal[6] = '{16'sd50, 16'sd100, 16'sd95, 16'sd85, 16'sd105, 16'sd115};
	logic               rlyExp[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic signed [15:0] curVal[3] = '{-16'sd50, 16'sd2000, 16'sd250};
	logic        [15:0] curExp[3] = '{16'h0fa0, 16'h4e20, 16'h1f40};
	logic signed [15:0] pwmVal[4] = '{-16'sd5, 16'sd1500, 16'sd256, 16'sd0};
	src_state_t         pwmSt[4]  = '{SRC_OK, SRC_OK, SRC_OK, SRC_ERROR};
	logic        [31:0] pwmExp[4] = '{32'd0, 32'd3000, 32'd750, 32'd2250};

	threshold_pwm_and_current_output #(.TICK_CYCLES(10)) dut (.clk(clk), .arst_n(arst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .src(src), .drive(drive), .irq(irq));
	pwm_load_model load (.clk(clk), .clear(clear), .drv(drive), .highCycles(highCycles),
		.shortHigh(shortHigh), .shortLow(shortLow), .loopUa(loopUa));

	////////////////////////////////////////////////////////////////
	// Free-running 50 MHz clock
	always #10 clk = ~clk;

	function automatic logic [7:0] ofs(input logic [3:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A gap cycle after each strobe keeps one assignment per signal per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge clk);
		regWrite  <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
	endtask

	task automatic setSrc(input logic signed [15:0] v, input src_state_t st, input int n);
		src <= '{v, st};
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pwmRun(input logic signed [15:0] v, input src_state_t st);
		setSrc(v, st, 2000);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (3000) @(posedge clk);
		#1;
	endtask

	// Read data is only valid in the cycle after the strobe, so sample it there
	always @(posedge clk) begin
		rdPend <= regRead;
		if (rdPend && expQ.size() > 0) begin
			chk(regRdData & mskQ.pop_front(), expQ.pop_front());
		end
	end

	// Watchdog sized well above the roughly 31k cycles the sequence needs
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		test_done();
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		arst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		src = '{16'sd0, SRC_OK};
		clear = 1'b0;
		n_fail = 0;
		num_checks = 0;
		void'($urandom(60191));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// Reset values, then an unmapped place
		foreach (rstIdx[i]) rd(ofs(rstIdx[i]), {16'h0, rstVal[i]}, 32'hffffffff);
		rd(8'h44, 32'h0, 32'hffffffff);
		wr(ofs(`IDX_PERIOD), 32'd50);
		rd(ofs(`IDX_PERIOD), 32'd100, 32'hffffffff);
		wr(ofs(`IDX_CTRL), 32'hffff);
		rd(ofs(`IDX_CTRL), 32'h7, 32'hffffffff);
		// Below-level relay, plain then with hysteresis
		wr(ofs(`IDX_RLY_LEVEL), 32'd100);
		wr(ofs(`IDX_RLY_HYST), 32'd0);
		foreach (rlyVal[i]) begin
			if (i == 2) wr(ofs(`IDX_RLY_HYST), 32'd10);
			setSrc(rlyVal[i], SRC_OK, 4);
			chk({31'h0, drive.relayOut}, {31'h0, rlyExp[i]});
		end
		// Current: clamping, linear map, random in-range values
		foreach (curVal[i]) begin
			setSrc(curVal[i], SRC_OK, 80);
			chk({16'h0, loopUa}, {16'h0, curExp[i]});
		end
		repeat (4) begin
			rv = $urandom % 1001;
			setSrc(16'(rv), SRC_OK, 80);
			chk({16'h0, loopUa}, 32'd4000 + 32'd16 * rv);
		end
		// Interrupt on alarm entry: masked source, sticky bit, write-one clear
		wr(`OFS_IRQ_MASK, 32'h1);
		wr(`OFS_IRQ_STAT, 32'hf);
		chk({31'h0, irq}, 32'h0);
		wr(ofs(`IDX_CUR_ALARM), 32'd1000);
		for (int s = 1; s < 4; s++) begin
			setSrc(16'sd500, src_state_t'(s), 80);
			chk({16'h0, loopUa}, 32'd3000);
			if (s == 1) begin
				chk({31'h0, irq}, 32'h1);
				rd(`OFS_IRQ_STAT, 32'h1, 32'h1);
				wr(`OFS_IRQ_STAT, 32'h1);
				chk({31'h0, irq}, 32'h0);
			end
		end
		wr(ofs(`IDX_CUR_ALARM), 32'd30000);
		setSrc(16'sd500, SRC_ERROR, 80);
		chk({16'h0, loopUa}, 32'd22000);
		wr(`OFS_IRQ_MASK, 32'h0);
		setSrc(16'sd500, SRC_OK, 4);
		chk({31'h0, irq}, 32'h0);
		// PWM duty over three whole periods of 1000 cycles
		wr(ofs(`IDX_MIN_ON), 32'd0);
		wr(ofs(`IDX_MIN_OFF), 32'd0);
		wr(ofs(`IDX_PWM_HI), 32'd1024);
		wr(ofs(`IDX_PWM_ALARM), 32'd768);
		foreach (pwmVal[i]) begin
			pwmRun(pwmVal[i], pwmSt[i]);
			chk(highCycles, pwmExp[i]);
		end
		// Minimum hold times stretch short pulses and short gaps
		wr(ofs(`IDX_MIN_ON), 32'd50);
		wr(ofs(`IDX_MIN_OFF), 32'd50);
		pwmRun(16'sd128, SRC_OK);
		// Upper bound proves a whole high run was seen at all
		chk({31'h0, shortHigh >= 32'd500 && shortHigh < 32'd1000}, 32'h1);
		pwmRun(16'sd896, SRC_OK);
		chk({31'h0, shortLow >= 32'd500 && shortLow < 32'd1000}, 32'h1);
		test_done();
	end
endmodule
